// ### dft_pkg.sv
// package: register map, reset values and timing constants for the dual fan tachometer counter
// What this block does
// [R1] counter restarts on tach edge or preload write
// [R2] restart on tach edge loads preload value
// [R3] counter saturates at 0xff, never wraps
// [R4] final count captured into read latch first
// [R5] second channel identical and fully independent
// [R6] threshold is AND of two count msbs
// [R7] threshold with enable raises microcontroller interrupt
// [R8] count follows half 1.966e6 over rpm*prescale
// [R9] latch invalid up to two pulses after preload
// [R10] preload rw reset 0x00, latch ro reset 0x00
// [R11] software sets preload 192 minus trigger count
// [R12] tach period gates 32.768 khz into counter
// [R13] prescale field 00/01/10/11 selects 1/2/4/8
// [R14] counter increments once per prescaled timebase tick
package dft_pkg;
   localparam int DFT_NCH = 2;
   localparam int DFT_CW = 8;
   localparam logic [15:0] DFT_A_LATCH_ADDR = 16'h7f9b;
   localparam logic [15:0] DFT_B_LATCH_ADDR = 16'h7f9c;
   localparam logic [15:0] DFT_A_PRELOAD_ADDR = 16'h7f9d;
   localparam logic [15:0] DFT_B_PRELOAD_ADDR = 16'h7f9e;
   localparam logic [7:0] DFT_PRELOAD_RST = 8'h00;
   localparam logic [7:0] DFT_LATCH_RST = 8'h00;
   localparam logic [7:0] DFT_COUNT_MAX = 8'hff;
   localparam logic [1:0] DFT_PRESCALE_RST = 2'h1;
   localparam int DFT_TB_MAX_CODE = 3;
   localparam int DFT_TB_DIV_W = 3;
   // timebase
   localparam int DFT_CLK_HZ = 250000000;
   localparam int DFT_TB_HZ = 32768;
   localparam int DFT_TB_CYCLES = DFT_CLK_HZ / DFT_TB_HZ;
   localparam int DFT_TB_CNT_W = 13;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [15:0] addr;
      logic [7:0] wdata;
   } dft_req_t;
endpackage : dft_pkg

// ### dft_counter.sv
// file: dual fan tachometer counter with preload, read latch and threshold detect
`timescale 1ns/1ps
module dft_counter import dft_pkg::*; #(
   parameter int TB_CYCLES = DFT_TB_CYCLES
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic fan_a_speed_input,
   input wire logic fan_b_speed_input,
   input wire dft_req_t req,
   input wire logic [1:0] prescale_a,
   input wire logic [1:0] prescale_b,
   input wire logic [1:0] irq_enable,
   output logic [7:0] rdata,
   output logic [1:0] threshold,
   output logic irq
);

   // timebase divider state
   logic [DFT_TB_CNT_W-1:0] tb_cnt_ff;
   logic [DFT_TB_CNT_W-1:0] nxt_tb_cnt;
   logic tb_tick_ff;
   logic nxt_tb_tick;

   // tach pin synchronisers and edge history
   logic [DFT_NCH-1:0] sync1_ff;
   logic [DFT_NCH-1:0] sync2_ff;
   logic [DFT_NCH-1:0] prev_ff;
   logic [DFT_NCH-1:0] rise;

   // per channel counting state
   logic [DFT_NCH-1:0] [DFT_CW-1:0] count_ff;
   logic [DFT_NCH-1:0] [DFT_CW-1:0] nxt_count;
   logic [DFT_NCH-1:0] [DFT_CW-1:0] latch_ff;
   logic [DFT_NCH-1:0] [DFT_CW-1:0] nxt_latch;
   logic [DFT_NCH-1:0] [DFT_CW-1:0] preload_ff;
   logic [DFT_NCH-1:0] [DFT_CW-1:0] nxt_preload;
   logic [DFT_NCH-1:0] [DFT_TB_DIV_W-1:0] div_ff;
   logic [DFT_NCH-1:0] [DFT_TB_DIV_W-1:0] nxt_div;
   logic [DFT_NCH-1:0] [DFT_TB_DIV_W-1:0] lim;
   logic [DFT_NCH-1:0] step;
   logic [DFT_NCH-1:0] pre_wr;
   logic [DFT_NCH-1:0] [1:0] psel;

   // bus side and status state
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic [DFT_NCH-1:0] thr_ff;
   logic [DFT_NCH-1:0] nxt_thr;
   logic irq_ff;
   logic nxt_irq;

   // prescale codes gathered per channel so the channel loop can index them
   assign psel[0] = prescale_a;
   assign psel[1] = prescale_b;

   // preload write decode, one strobe per channel
   assign pre_wr[0] = req.wr && (req.addr == DFT_A_PRELOAD_ADDR); // R1
   assign pre_wr[1] = req.wr && (req.addr == DFT_B_PRELOAD_ADDR); // R1

   // rising edge seen on the synchronised pin; idle low matches reset low
   assign rise = sync2_ff & ~prev_ff;

   // 32.768 khz timebase tick from the system clock
   always_comb begin
      nxt_tb_tick = (tb_cnt_ff == DFT_TB_CNT_W'(TB_CYCLES - 1)); // R12
      if (nxt_tb_tick) begin
         nxt_tb_cnt = '0;
      end else begin
         nxt_tb_cnt = tb_cnt_ff + 1'b1;
      end
   end

   // timebase registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         tb_cnt_ff <= '0;
         tb_tick_ff <= 1'b0;
      end else begin
         tb_cnt_ff <= nxt_tb_cnt;
         tb_tick_ff <= nxt_tb_tick;
      end
   end

   // two flops per pin before any logic looks at it, third keeps history
   always_ff @(posedge clk) begin
      if (!nrst) begin
         sync1_ff <= '0;
         sync2_ff <= '0;
         prev_ff <= '0;
      end else begin
         sync1_ff <= {fan_b_speed_input, fan_a_speed_input};
         sync2_ff <= sync1_ff;
         prev_ff <= sync2_ff;
      end
   end

   // per channel prescaler, counter, latch and preload
   for (genvar i = 0; i < DFT_NCH; i++) begin : g_ch

      // prescaler: one count step per 1, 2, 4 or 8 timebase ticks
      always_comb begin
         lim[i] = DFT_TB_DIV_W'((1 << psel[i]) - 1); // R13
         step[i] = tb_tick_ff && (div_ff[i] >= lim[i]); // R14
         nxt_div[i] = div_ff[i];
         if (rise[i] || pre_wr[i]) begin
            nxt_div[i] = '0; // restart aligns the divider to the new period
         end else if (tb_tick_ff) begin
            if (step[i]) begin
               nxt_div[i] = '0;
            end else begin
               nxt_div[i] = div_ff[i] + 1'b1;
            end
         end
      end

      // preload register; latch may read stale for two pulses after a write
      always_comb begin
         if (pre_wr[i]) begin
            nxt_preload[i] = req.wdata; // R10 R9
         end else begin
            nxt_preload[i] = preload_ff[i];
         end
      end

      // read latch takes the finished count before the restart
      always_comb begin
         if (rise[i]) begin
            nxt_latch[i] = count_ff[i]; // R4 R5
         end else begin
            nxt_latch[i] = latch_ff[i];
         end
      end

      // pulse counter: write beats edge, edge beats step, saturates at top
      always_comb begin
         if (pre_wr[i]) begin
            nxt_count[i] = req.wdata; // R1
         end else if (rise[i]) begin
            nxt_count[i] = preload_ff[i]; // R1 R2
         end else if (step[i] && count_ff[i] != DFT_COUNT_MAX) begin
            nxt_count[i] = count_ff[i] + 1'b1; // R14 R8 R12
         end else begin
            nxt_count[i] = count_ff[i]; // R3
         end
      end

      // channel registers
      always_ff @(posedge clk) begin
         if (!nrst) begin
            div_ff[i] <= '0;
            count_ff[i] <= '0;
            latch_ff[i] <= DFT_LATCH_RST; // R10
            preload_ff[i] <= DFT_PRELOAD_RST; // R10
         end else begin
            div_ff[i] <= nxt_div[i];
            count_ff[i] <= nxt_count[i];
            latch_ff[i] <= nxt_latch[i];
            preload_ff[i] <= nxt_preload[i];
         end
      end

      // threshold: both top count bits set means 192 or more
      always_comb begin
         nxt_thr[i] = &count_ff[i][DFT_CW-1:DFT_CW-2]; // R6
      end
   end

   // read mux; latch addresses are read only, unmapped reads give zero
   always_comb begin
      nxt_rdata = rdata_ff;
      if (req.rd) begin
         unique case (req.addr)
            DFT_A_LATCH_ADDR: nxt_rdata = latch_ff[0];
            DFT_B_LATCH_ADDR: nxt_rdata = latch_ff[1];
            DFT_A_PRELOAD_ADDR: nxt_rdata = preload_ff[0];
            DFT_B_PRELOAD_ADDR: nxt_rdata = preload_ff[1];
            default: nxt_rdata = 8'h00;
         endcase
      end
   end

   // read data register holds until the next read
   always_ff @(posedge clk) begin
      if (!nrst) begin
         rdata_ff <= 8'h00;
      end else begin
         rdata_ff <= nxt_rdata;
      end
   end

   // interrupt request uses next threshold so both move on one edge
   always_comb begin
      nxt_irq = |(nxt_thr & irq_enable); // R7
   end

   // status registers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         thr_ff <= '0;
         irq_ff <= 1'b0;
      end else begin
         thr_ff <= nxt_thr;
         irq_ff <= nxt_irq;
      end
   end

   // outputs straight from flops
   assign rdata = rdata_ff;
   assign threshold = thr_ff;
   assign irq = irq_ff;

endmodule : dft_counter

// ### dft_fan_model.sv
// fan tach source: square wave of fixed period while run is high
`timescale 1ns/1ps
module dft_fan_model #(parameter int HALF = 100) (
   input wire logic clk,
   input wire logic run,
   output logic tach
);
   int n = 0;
   initial tach = 1'b0;
   // two edges per revolution, one rising edge per pulse period
   always @(posedge clk) if (run) begin
      n <= (n == HALF - 1) ? 0 : n + 1;
      if (n == HALF - 1) tach <= ~tach;
   end
endmodule : dft_fan_model

// ### dft_counter_assertions.sv
// port checker for the dual fan tachometer counter
`timescale 1ns/1ps
module dft_assertions import dft_pkg::*; (
   input wire logic clk,
   input wire logic nrst,
   input wire logic fan_a_speed_input,
   input wire logic fan_b_speed_input,
   input wire dft_req_t req,
   input wire logic [1:0] prescale_a,
   input wire logic [1:0] prescale_b,
   input wire logic [1:0] irq_enable,
   input wire logic [7:0] rdata,
   input wire logic [1:0] threshold,
   input wire logic irq
);
   // reset clears, interrupt follows threshold, reads and preload writes
   rst_clear_a: assert property (@(posedge clk) !nrst |=> !irq && threshold == 2'h0 && rdata == 8'h00)
      else $error("outputs not cleared by reset");
   irq_match_a: assert property (@(posedge clk) disable iff (!nrst) $stable(irq_enable) |-> irq == |(irq_enable & threshold))
      else $error("irq differs from enabled threshold");
   irq_cause_a: assert property (@(posedge clk) disable iff (!nrst) irq |-> threshold != 2'h0)
      else $error("irq without threshold");
   rd_unmapped_a: assert property (@(posedge clk) disable iff (!nrst)
      req.rd && !(req.addr inside {[16'h7f9b:16'h7f9e]}) |=> rdata == 8'h00) else $error("unmapped read not zero");
   rd_hold_a: assert property (@(posedge clk) disable iff (!nrst) !req.rd |=> $stable(rdata))
      else $error("read data moved without read");
   wr_lo_a: assert property (@(posedge clk) disable iff (!nrst) req.wr && req.addr == DFT_A_PRELOAD_ADDR
      && req.wdata < 8'hc0 |-> ##[1:2] !threshold[0]) else $error("threshold a kept after low preload");
   wr_hi_a: assert property (@(posedge clk) disable iff (!nrst) req.wr && req.addr == DFT_A_PRELOAD_ADDR
      && req.wdata >= 8'hc0 |-> ##[1:2] threshold[0]) else $error("threshold a missing after high preload");
   wr_hi_b_a: assert property (@(posedge clk) disable iff (!nrst) req.wr && req.addr == DFT_B_PRELOAD_ADDR
      && req.wdata >= 8'hc0 |-> ##[1:2] threshold[1]) else $error("threshold b missing after high preload");
endmodule : dft_assertions
bind dft_counter dft_assertions u_chk(.*);

// ### testbench.sv
// self-checking bench for the dual fan tachometer counter
`timescale 1ns/1ps
module testbench import dft_pkg::*;;
   localparam int EXP = 200 / (4 * 2);
   logic clk = 1'b0, nrst = 1'b0, run = 1'b0, irq;
   logic [1:0] ien = 2'h0, thr;
   logic [1:0] pa = 2'h1;
   logic [1:0] pb = 2'h0;
   logic [7:0] rdata;
   wire logic fa, fb;
   dft_req_t req = '0;
   int err_count = 0, compares = 0;
   initial forever #2 clk = ~clk;
   dft_fan_model #(.HALF(100)) u_fa(.clk(clk), .run(run), .tach(fa));
   dft_fan_model #(.HALF(1000)) u_fb(.clk(clk), .run(run), .tach(fb));
   dft_counter #(.TB_CYCLES(4)) u_dut(.clk(clk), .nrst(nrst), .fan_a_speed_input(fa), .fan_b_speed_input(fb),
      .req(req), .prescale_a(pa), .prescale_b(pb), .irq_enable(ien), .rdata(rdata), .threshold(thr), .irq(irq));
   task automatic chk(input logic [7:0] g, input logic [7:0] lo, input logic [7:0] hi);
      compares++;
      if ((g >= lo && g <= hi) !== 1'b1) begin
         err_count++;
         $display("mismatch %0t got %h want %h..%h", $time, g, lo, hi);
      end
   endtask : chk
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(negedge clk) req = '{1'b1, 1'b0, a, d};
      @(negedge clk) req = '0;
   endtask : wr
   task automatic rd(input logic [15:0] a, input logic [7:0] lo, input logic [7:0] hi);
      @(negedge clk) req = '{1'b0, 1'b1, a, 8'h00};
      @(negedge clk) req = '0;
      chk(rdata, lo, hi);
   endtask : rd
   task automatic t_reset();
      wr(DFT_A_LATCH_ADDR, 8'h55);
      for (int i = 0; i < 5; i++) rd(16'h7f9b + 16'(i), 8'h00, 8'h00);
   endtask : t_reset
   task automatic t_count();
      run = 1'b1;
      repeat (6000) @(negedge clk);
      rd(DFT_A_LATCH_ADDR, 8'(EXP - 1), 8'(EXP + 1));
      rd(DFT_B_LATCH_ADDR, 8'hff, 8'hff);
   endtask : t_count
   task automatic t_thresh();
      ien = 2'h1;
      wr(DFT_A_PRELOAD_ADDR, 8'hc0);
      repeat (3) @(negedge clk);
      chk({7'h0, thr[0] & irq}, 8'h01, 8'h01);
      repeat (600) @(negedge clk);
      rd(DFT_A_LATCH_ADDR, 8'(192 + EXP - 1), 8'(192 + EXP + 1));
      ien = 2'h0;
      repeat (2) @(negedge clk);
      chk({7'h0, irq}, 8'h00, 8'h00);
      rd(DFT_A_PRELOAD_ADDR, 8'hc0, 8'hc0);
      wr(DFT_A_PRELOAD_ADDR, 8'h00);
      repeat (3) @(negedge clk);
      chk({7'h0, thr[0]}, 8'h00, 8'h00);
      wr(DFT_B_PRELOAD_ADDR, 8'hc0);
      rd(DFT_B_PRELOAD_ADDR, 8'hc0, 8'hc0);
      ien = 2'h2;
      repeat (3) @(negedge clk);
      chk({7'h0, thr[1] & irq}, 8'h01, 8'h01);
   endtask : t_thresh
   // every prescale code on channel a, preload back at zero
   task automatic t_prescale();
      for (int c = 0; c < 4; c++) begin
         pa = 2'(c);
         repeat (700) @(negedge clk);
         rd(DFT_A_LATCH_ADDR, 8'(200 / (4 << c) - 1), 8'(200 / (4 << c) + 1));
      end
   endtask : t_prescale
   // reset in mid run clears registers and status
   task automatic t_rerun();
      @(negedge clk) nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      chk({6'h0, thr}, 8'h00, 8'h00);
      rd(DFT_B_PRELOAD_ADDR, 8'h00, 8'h00);
      rd(DFT_A_LATCH_ADDR, 8'h00, 8'h00);
   endtask : t_rerun
   task automatic give_verdict();
      $display("compares %0d err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : give_verdict
   // reset, then the scenarios in order
   initial begin
      repeat (16) @(negedge clk);
      nrst = 1'b1;
      t_reset();
      t_count();
      t_thresh();
      t_prescale();
      t_rerun();
      give_verdict();
   end
endmodule : testbench
